// >>> bench/beep_tone_generator_assertions.sv
/*
 * Port-level checker for the beep tone generator, bound to its top.
 * Assumes one clock domain and the asynchronous active-low reset.
 */
`timescale 1ns/1ps
`include "beep_tone_map.vh"

module beep_tone_generator_assertions #(
   parameter MODE_WIDTH = 5                 // selector width
) (
   input wire                  clk_sys_i,     // system clock
   input wire                  rstn_i,        // reset, active low
   input wire                  ce_i,          // clock enable
   input wire [7:0]            reg_addr_i,    // register offset
   input wire                  reg_wr_i,      // write strobe
   input wire [7:0]            reg_wdata_i,   // write data
   input wire                  reg_rd_i,      // read strobe
   input wire [7:0]            reg_rdata_o,   // read data
   input wire                  reg_rvalid_o,  // read data valid
   input wire                  sample_tick_i, // sample tick
   input wire [MODE_WIDTH-1:0] playback_processing_block_i, // mode
   input wire                  tone_valid_o,  // tone strobe
   input wire [15:0]           tone_sample_o, // tone sample
   input wire                  tone_active_o  // beep running
);
   // ---------------------------------------------------------------
   // helper terms
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   // control write and accepted tick
   wire ctl_wr = reg_wr_i && (reg_addr_i == `TONE_CONTROL_ADDR);
   wire ctl_set = ctl_wr && reg_wdata_i[`TONE_ENABLE_BIT];
   wire take   = ce_i && sample_tick_i && tone_active_o &&
                 (playback_processing_block_i ==
                  `DAC_PROCESSING_BLOCK_TWENTYFIVE);

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   read_answer_a: assert property (ce_i && reg_rd_i |=> reg_rvalid_o)
      else $error("read answer missing");
   read_pulse_a: assert property (ce_i && !reg_rd_i |=> !reg_rvalid_o)
      else $error("read valid without read");
   rdata_hold_a: assert property (ce_i && !reg_rd_i |=>
      $stable(reg_rdata_o))
      else $error("read data moved without read");
   tone_answer_a: assert property (take && !ctl_wr |=> tone_valid_o)
      else $error("accepted tick gave no sample");
   tone_gate_a: assert property (ce_i && !take |=> !tone_valid_o)
      else $error("tone sample without accepted tick");
   start_cause_a: assert property ($rose(tone_active_o) |->
      $past(ctl_set))
      else $error("beep started without enable write");
   self_clear_a: assert property ($fell(tone_active_o) &&
      !$past(ctl_wr) |-> $past(take))
      else $error("beep ended without a counted tick");
   idle_silent_a: assert property (
      ce_i && $past(ce_i) && !tone_active_o && !tone_valid_o &&
      !$past(tone_active_o) |-> tone_sample_o == 16'h0000)
      else $error("tone output not silent while idle");

   // main scenarios seen
   cover property ($rose(tone_active_o));
   cover property (take ##1 $fell(tone_active_o));
   cover property (ce_i && sample_tick_i && tone_active_o && !take);
endmodule

bind beep_tone_generator beep_tone_generator_assertions #(
   .MODE_WIDTH(MODE_WIDTH)
) u_chk (
   .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
   .sample_tick_i(sample_tick_i),
   .playback_processing_block_i(playback_processing_block_i),
   .tone_valid_o(tone_valid_o), .tone_sample_o(tone_sample_o),
   .tone_active_o(tone_active_o)
);

// >>> bench/playback_path_model.sv
/*
 * Playback path model: random sample ticks and the processing mode.
 * Assumes the bench gates it with run and picks the wrong mode.
 */
`timescale 1ns/1ps

module playback_path_model (
   input  wire       clk_sys_i,    // system clock
   input  wire       run_i,        // ticks allowed
   input  wire       wrong_mode_i, // select a non-tone mode
   output reg        tick_o,       // one pulse per sample
   output reg  [4:0] mode_o        // processing-block mode
);
   // random spacing, back-to-back ticks included
   always @(posedge clk_sys_i) begin
      tick_o <= run_i && ($urandom_range(1, 0) == 1);
      mode_o <= wrong_mode_i ? 5'h18 : 5'h19;
   end
endmodule

// >>> bench/testbench.sv
/*
 * Self-checking bench: register reset, readback, beeps, refusal,
 * abort and reset in mid-beep. Notes kept in queues, checked by a
 * monitor. Assumes the design header is on the include path.
 */
`timescale 1ns/1ps
`include "beep_tone_map.vh"

module testbench;
   reg clk_sys_i = 0, rstn_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
   reg [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, d;
   reg run = 0, wrong = 0, prev_act = 0;
   wire [7:0] reg_rdata_o;
   wire reg_rvalid_o, sample_tick_i, tone_valid_o, tone_active_o;
   wire [4:0] mode;
   wire [15:0] tone_sample_o;
   reg [15:0] smp2;
   reg signed [15:0] s_a, s_b;
   integer err_count = 0, num_checks = 0, cycles = 0, beat = 0, i, k;
   logic [7:0] rq[$];
   int tq[$];
   logic [7:0] rstv [0:9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hEE, 8'h10,
                              8'hD8, 8'h7E, 8'hE3, `UNMAPPED_READ_VALUE};

   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   beep_tone_generator dut (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
      .sample_tick_i(sample_tick_i), .playback_processing_block_i(mode),
      .tone_valid_o(tone_valid_o), .tone_sample_o(tone_sample_o),
      .tone_active_o(tone_active_o));

   playback_path_model u_path (.clk_sys_i(clk_sys_i), .run_i(run),
      .wrong_mode_i(wrong), .tick_o(sample_tick_i), .mode_o(mode));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task check(input bit ok, input string msg);
      num_checks++;
      if (!ok) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task stop_test;
      $display("errors %0d checks %0d", err_count, num_checks);
      if (err_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task wr(input [7:0] a, input [7:0] v);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask

   // the expected byte is noted before the read goes out
   task rd(input [7:0] a, input [7:0] e);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      rq.push_back(e);
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
   endtask

   // reserved bit 6 always written as zero
   task ctl(input [7:0] v);
      wr(`TONE_CONTROL_ADDR, v & 8'hBF);
   endtask

   task set_len(input [23:0] n);
      wr(`TONE_LENGTH_HIGH_ADDR, n[23:16]);
      wr(`TONE_LENGTH_MIDDLE_ADDR, n[15:8]);
      wr(`TONE_LENGTH_LOW_ADDR, n[7:0]);
   endtask

   // wrong mode first: ticks must neither sound nor count down
   task beep(input [23:0] n, input [5:0] lvl, input bit wr_mode);
      set_len(n);
      tq.push_back(n);
      wrong <= wr_mode;
      ctl({2'b10, lvl});
      run <= 1'b1;
      repeat (12) @(posedge clk_sys_i);
      if (wr_mode)
         check(tone_active_o === 1'b1 && beat == 0, "mode gate");
      wrong <= 1'b0;
      for (k = 0; k < 3000 && tone_active_o === 1'b1; k++)
         @(posedge clk_sys_i);
      run <= 1'b0;
      rd(`TONE_CONTROL_ADDR, {2'b00, lvl});
   endtask

   // ---------------------------------------------------------------
   // monitor: takes the oldest note whenever a result appears
   // ---------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         beat = 0;
         prev_act = 0;
      end else begin
         if (reg_rvalid_o === 1'b1) begin
            if (rq.size() == 0)
               check(0, "read data not asked for");
            else
               check(reg_rdata_o === rq.pop_front(), "read data");
         end
         if (tone_valid_o === 1'b1) begin
            if (beat == 0)
               check(tone_sample_o === 16'h0000, "first sample");
            if (beat == 1)
               smp2 = tone_sample_o;
            beat++;
         end
         if (prev_act && tone_active_o === 1'b0) begin
            check(tq.size() > 0 && beat == tq.pop_front(), "length");
            beat = 0;
         end
         prev_act = (tone_active_o === 1'b1);
      end
   end

   // hang guard, far above the fewer than one thousand cycles needed
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         $display("CHECK FAILED at %0t: timeout", $time);
         stop_test;
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(3));
      repeat (2) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      for (i = 0; i < 10; i++)
         rd(8'h47 + i, rstv[i]);
      wr(8'h50, 8'hFF);
      rd(8'h50, `UNMAPPED_READ_VALUE);
      for (i = 1; i < 9; i++) begin
         d = $urandom;
         wr(8'h47 + i, d);
         rd(8'h47 + i, d);
      end
      for (i = 5; i < 9; i++)
         wr(8'h47 + i, rstv[i]);
      beep($urandom_range(6, 1), $urandom_range(63, 0), 1);
      beep(24'h000100, 6'h3F, 0);
      beep(2, 6'h00, 0);
      s_a = smp2;
      beep(2, 6'h06, 0);
      s_b = smp2;
      check(s_b > 0 && s_a - 2*s_b <= 3 && 2*s_b - s_a <= 3, "level");
      set_len(0);
      ctl(8'h80);
      rd(`TONE_CONTROL_ADDR, 8'h00);
      set_len(100);
      tq.push_back(0);
      ctl(8'h85);
      // writes while frozen must be dropped
      ce_i <= 1'b0;
      ctl(8'h05);
      ce_i <= 1'b1;
      rd(`TONE_CONTROL_ADDR, 8'h85);
      ctl(8'h05);
      rd(`TONE_CONTROL_ADDR, 8'h05);
      set_len(50);
      ctl(8'h80);
      run <= 1'b1;
      repeat (20) @(posedge clk_sys_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      run <= 1'b0;
      rd(`TONE_CONTROL_ADDR, 8'h00);
      rd(`TONE_LENGTH_LOW_ADDR, 8'hEE);
      repeat (4) @(posedge clk_sys_i);
      stop_test;
   end
endmodule

// >>> design/beep_tone_generator.v
/*
 * Beep tone generator of the DAC playback path: byte register file,
 * duration counter, recursive oscillator and level scaling.
 * Assumes a host byte register port synchronous to clk_sys_i and a
 * one-cycle sample tick per DAC word clock from the playback path.
 */
`timescale 1ns/1ps
`include "beep_tone_map.vh"

module beep_tone_generator #(
   parameter LENGTH_WIDTH = 24,    // duration counter width
   parameter MODE_WIDTH   = 5      // processing-block selector width
) (
   input  wire                  clk_sys_i,    // system clock, 40 MHz
   input  wire                  rstn_i,       // async reset, active low
   input  wire                  ce_i,         // clock enable, freezes all
   input  wire [7:0]            reg_addr_i,   // register offset
   input  wire                  reg_wr_i,     // write strobe
   input  wire [7:0]            reg_wdata_i,  // write data
   input  wire                  reg_rd_i,     // read strobe
   output reg  [7:0]            reg_rdata_o,  // read data, next cycle
   output reg                   reg_rvalid_o, // read data valid pulse
   input  wire                  sample_tick_i, // one pulse per DAC sample
   input  wire [MODE_WIDTH-1:0] playback_processing_block_i, // mode
   output wire                  tone_valid_o, // tone sample strobe
   output wire [15:0]           tone_sample_o, // scaled tone sample
   output reg                   tone_active_o // beep in progress
);

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   reg                    enable;         // control bit 7
   reg                    rsvd_bit;       // control bit 6, plain storage
   reg  [5:0]             level;          // control bits 5..0
   reg  [7:0]             rsvd_byte;      // reserved byte after control
   reg  [7:0]             length_high;
   reg  [7:0]             length_middle;
   reg  [7:0]             length_low;
   reg  [7:0]             sine_high;
   reg  [7:0]             sine_low;
   reg  [7:0]             cosine_high;
   reg  [7:0]             cosine_low;

   reg  [LENGTH_WIDTH-1:0] remaining;     // samples still to emit
   reg  [7:0]              next_rdata;

   wire                    wr_control;
   wire                    host_start;
   wire                    host_stop;
   wire                    mode_ok;
   wire                    sample_go;
   wire                    last_sample;
   wire [LENGTH_WIDTH-1:0] length_total;
   wire                    length_zero;
   wire [15:0]             sine_coeff;
   wire [15:0]             cosine_coeff;
   wire [15:0]             osc_sample;

   // ----------------------------------------------------------------
   // decode and derived terms
   // ----------------------------------------------------------------
   // RL5: three bytes form one count
   assign length_total = {length_high, length_middle, length_low};
   assign length_zero  = (length_total == {LENGTH_WIDTH{1'b0}});
   // RL7: sine coefficient from two bytes
   assign sine_coeff   = {sine_high, sine_low};
   // RL8: cosine coefficient from two bytes
   assign cosine_coeff = {cosine_high, cosine_low};

   assign wr_control = reg_wr_i && (reg_addr_i == `TONE_CONTROL_ADDR);
   // RL1: rising write of the enable bit
   assign host_start = wr_control && reg_wdata_i[`TONE_ENABLE_BIT] &&
                       !enable && !length_zero;
   // a zero write while running aborts the beep
   assign host_stop  = wr_control && !reg_wdata_i[`TONE_ENABLE_BIT];

   // RL9: only the one processing mode may beep
   assign mode_ok = (playback_processing_block_i ==
                     `DAC_PROCESSING_BLOCK_TWENTYFIVE);

   // RL2: no samples without enable
   assign sample_go   = enable && mode_ok && sample_tick_i;
   // RL11: final sample when one is left
   assign last_sample = sample_go &&
                        (remaining == {{(LENGTH_WIDTH-1){1'b0}}, 1'b1});

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   // enable: host start needs enable clear, so it never meets the self-clear;
   // a restart written as the old beep ends is lost
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         // RL2: enable clear after reset
         enable   <= 1'b0;
         rsvd_bit <= 1'b0;
         level    <= 6'h00;
      end else if (ce_i) begin
         if (wr_control) begin
            // RL4: bit 6 kept as written; host keeps it at zero
            rsvd_bit <= reg_wdata_i[`TONE_RSVD_BIT];
            // RL3: level code stored for the scaler
            level    <= reg_wdata_i[`TONE_LEVEL_MSB:`TONE_LEVEL_LSB];
         end
         if (host_start) begin
            enable <= 1'b1;
         end else if (host_stop) begin
            enable <= 1'b0;
         end else if (last_sample) begin
            // RL1: self-clear at end of duration
            enable <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // data registers
   // ----------------------------------------------------------------
   // cosine acts live, sine is taken only at start; length is latched only at start
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rsvd_byte     <= `TONE_RSVD_RST;
         // RL6: length reset bytes
         length_high   <= `TONE_LENGTH_HIGH_RST;
         length_middle <= `TONE_LENGTH_MIDDLE_RST;
         length_low    <= `TONE_LENGTH_LOW_RST;
         // RL7: sine reset bytes
         sine_high     <= `TONE_SINE_HIGH_RST;
         sine_low      <= `TONE_SINE_LOW_RST;
         // RL8: cosine reset bytes
         cosine_high   <= `TONE_COSINE_HIGH_RST;
         cosine_low    <= `TONE_COSINE_LOW_RST;
      end else if (ce_i && reg_wr_i) begin
         case (reg_addr_i)
            `TONE_RSVD_ADDR:          rsvd_byte     <= reg_wdata_i;
            `TONE_LENGTH_HIGH_ADDR:   length_high   <= reg_wdata_i;
            `TONE_LENGTH_MIDDLE_ADDR: length_middle <= reg_wdata_i;
            `TONE_LENGTH_LOW_ADDR:    length_low    <= reg_wdata_i;
            `TONE_SINE_HIGH_ADDR:     sine_high     <= reg_wdata_i;
            `TONE_SINE_LOW_ADDR:      sine_low      <= reg_wdata_i;
            `TONE_COSINE_HIGH_ADDR:   cosine_high   <= reg_wdata_i;
            `TONE_COSINE_LOW_ADDR:    cosine_low    <= reg_wdata_i;
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // duration counter
   // ----------------------------------------------------------------
   // RL11: load at start, one count per emitted sample
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         remaining <= {LENGTH_WIDTH{1'b0}};
      end else if (ce_i) begin
         if (host_start) begin
            // RL5: exactly length_total samples follow
            remaining <= length_total;
         end else if (host_stop) begin
            remaining <= {LENGTH_WIDTH{1'b0}};
         end else if (sample_go) begin
            remaining <= remaining - {{(LENGTH_WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // busy flag follows the enable bit
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tone_active_o <= 1'b0;
      end else if (ce_i) begin
         if (host_start) begin
            tone_active_o <= 1'b1;
         end else if (host_stop || last_sample) begin
            tone_active_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   // control reads back the live enable, so software can poll the end
   always @* begin
      next_rdata = `UNMAPPED_READ_VALUE;
      case (reg_addr_i)
         `TONE_CONTROL_ADDR:       next_rdata = {enable, rsvd_bit, level};
         `TONE_RSVD_ADDR:          next_rdata = rsvd_byte;
         `TONE_LENGTH_HIGH_ADDR:   next_rdata = length_high;
         `TONE_LENGTH_MIDDLE_ADDR: next_rdata = length_middle;
         `TONE_LENGTH_LOW_ADDR:    next_rdata = length_low;
         `TONE_SINE_HIGH_ADDR:     next_rdata = sine_high;
         `TONE_SINE_LOW_ADDR:      next_rdata = sine_low;
         `TONE_COSINE_HIGH_ADDR:   next_rdata = cosine_high;
         `TONE_COSINE_LOW_ADDR:    next_rdata = cosine_low;
         default:                  next_rdata = `UNMAPPED_READ_VALUE;
      endcase
   end

   // read data registered one cycle after the strobe
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o  <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end else if (ce_i) begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // oscillator and level scaling
   // ----------------------------------------------------------------
   // RL10: one oscillator step per emitted sample
   tone_oscillator u_osc (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .ce_i      (ce_i),
      .load_i    (host_start),
      .step_i    (sample_go),
      .sine_i    (sine_coeff),
      .cosine_i  (cosine_coeff),
      .sample_o  (osc_sample)
   );

   // RL10: scale by the level before output
   // RL2: silence forced while disabled
   tone_level_scaler u_scale (
      .clk_sys_i    (clk_sys_i),
      .rstn_i       (rstn_i),
      .ce_i         (ce_i),
      .clear_i      (!enable),
      .in_valid_i   (sample_go),
      .in_sample_i  (osc_sample),
      .level_i      (level),
      .out_valid_o  (tone_valid_o),
      .out_sample_o (tone_sample_o)
   );

endmodule

// >>> design/beep_tone_map.vh
/*
 * Register map, field positions and reset values of the beep tone
 * generator byte registers, plus the processing-mode code it needs.
 * Assumes an 8-bit register space addressed by an 8-bit offset.
 */
// Behaviour
// RL1: setting enable bit 7 starts the tone; hardware clears it when done
// RL2: enable bit reads zero after reset; no tone while it is zero
// RL3: six-bit level, code zero is +2 dB, minus 1 dB per code step
// RL4: host writes only the reset value into reserved bit 6
// RL5: 24-bit length from three bytes; tone lasts exactly that many samples
// RL6: length bytes reset to 0x00, 0x00 and 0xEE
// RL7: 16-bit sine coefficient in two bytes, reset 0x10 and 0xD8
// RL8: 16-bit cosine coefficient in two bytes, reset 0x7E and 0xE3
// RL9: tone only produced in processing-block mode twenty-five
// RL10: recursive oscillator makes each sample, then level scaling
// RL11: counter loads length, counts down per sample, stops at zero
`ifndef BEEP_TONE_MAP_VH
`define BEEP_TONE_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TONE_CONTROL_ADDR        8'h47
`define TONE_RSVD_ADDR           8'h48
`define TONE_LENGTH_HIGH_ADDR    8'h49
`define TONE_LENGTH_MIDDLE_ADDR  8'h4A
`define TONE_LENGTH_LOW_ADDR     8'h4B
`define TONE_SINE_HIGH_ADDR      8'h4C
`define TONE_SINE_LOW_ADDR       8'h4D
`define TONE_COSINE_HIGH_ADDR    8'h4E
`define TONE_COSINE_LOW_ADDR     8'h4F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TONE_ENABLE_BIT          7
`define TONE_RSVD_BIT            6
`define TONE_LEVEL_MSB           5
`define TONE_LEVEL_LSB           0

// ----------------------------------------------------------------
// reset values and unmapped read value
// ----------------------------------------------------------------
`define TONE_CONTROL_RST         8'h00
`define TONE_RSVD_RST            8'h00
`define TONE_LENGTH_HIGH_RST     8'h00
`define TONE_LENGTH_MIDDLE_RST   8'h00
`define TONE_LENGTH_LOW_RST      8'hEE
`define TONE_SINE_HIGH_RST       8'h10
`define TONE_SINE_LOW_RST        8'hD8
`define TONE_COSINE_HIGH_RST     8'h7E
`define TONE_COSINE_LOW_RST      8'hE3
`define UNMAPPED_READ_VALUE      8'h00

// ----------------------------------------------------------------
// processing mode and level scaling
// ----------------------------------------------------------------
`define DAC_PROCESSING_BLOCK_TWENTYFIVE 5'h19
`define LEVEL_OFFSET             7'h04
`define LEVEL_STEPS_PER_SHIFT    7'h06
`define LEVEL_BASE_SHIFT         6'h0E

`endif

// >>> design/tone_level_scaler.v
/*
 * Scales one oscillator sample by the six-bit level code.
 * Assumes one valid sample at most per clock; result one cycle later.
 */
`timescale 1ns/1ps
`include "beep_tone_map.vh"

module tone_level_scaler (
   input  wire        clk_sys_i,   // system clock
   input  wire        rstn_i,      // async reset, active low
   input  wire        ce_i,        // clock enable
   input  wire        clear_i,     // force silence
   input  wire        in_valid_i,  // sample present
   input  wire [15:0] in_sample_i, // raw sample
   input  wire [5:0]  level_i,     // level code
   output reg         out_valid_o, // scaled sample strobe
   output reg  [15:0] out_sample_o // scaled sample
);

   wire [6:0]         steps;
   wire [6:0]         coarse;
   wire [6:0]         fine;
   wire [5:0]         shift;
   reg  [15:0]        mant;
   wire signed [32:0] prod;
   wire signed [32:0] scaled;
   wire [15:0]        sat;

   // ----------------------------------------------------------------
   // gain = 2 * 10^(-fine/20) * 2^-coarse, 6 dB per shift
   // ----------------------------------------------------------------
   // RL3: code zero is +2 dB, one dB per step
   assign steps  = {1'b0, level_i} + `LEVEL_OFFSET;
   assign coarse = steps / `LEVEL_STEPS_PER_SHIFT;
   assign fine   = steps % `LEVEL_STEPS_PER_SHIFT;
   assign shift  = `LEVEL_BASE_SHIFT + coarse[5:0];

   // fine dB table, Q1.15; 6 dB per shift is a 0.02 dB approximation
   always @* begin
      case (fine[2:0])
         3'h0:    mant = 16'h7FFF;
         3'h1:    mant = 16'h7214;
         3'h2:    mant = 16'h65AC;
         3'h3:    mant = 16'h5A9D;
         3'h4:    mant = 16'h50C3;
         3'h5:    mant = 16'h47FB;
         default: mant = 16'h7FFF;
      endcase
   end

   assign prod   = $signed(in_sample_i) * $signed({1'b0, mant});
   assign scaled = prod >>> shift;
   // +2 dB can exceed full scale, so clip
   assign sat = (scaled > 33'sh0_0000_7FFF) ? 16'h7FFF :
                (scaled < -33'sh0_0000_8000) ? 16'h8000 :
                scaled[15:0];

   // output register; a valid sample beats a clear
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_valid_o  <= 1'b0;
         out_sample_o <= 16'h0000;
      end else if (ce_i) begin
         out_valid_o <= in_valid_i;
         if (in_valid_i) begin
            out_sample_o <= sat;
         end else if (clear_i) begin
            out_sample_o <= 16'h0000;
         end
      end
   end

endmodule

// >>> design/tone_oscillator.v
/*
 * Second-order recursive sine oscillator, Q1.15 arithmetic.
 * Assumes coefficients are sin(w) and cos(w) of the same angle and
 * that step pulses arrive once per DAC sample.
 */
`timescale 1ns/1ps
`include "beep_tone_map.vh"

module tone_oscillator (
   input  wire        clk_sys_i,   // system clock
   input  wire        rstn_i,      // async reset, active low
   input  wire        ce_i,        // clock enable
   input  wire        load_i,      // restart at phase zero
   input  wire        step_i,      // advance one sample
   input  wire [15:0] sine_i,      // sin(w), Q1.15
   input  wire [15:0] cosine_i,    // cos(w), Q1.15
   output reg  [15:0] sample_o     // current sample y[n]
);

   reg  [15:0]        prev;        // y[n-1]
   wire signed [33:0] prod;
   wire signed [33:0] next_wide;
   wire [15:0]        next_sample;

   // ----------------------------------------------------------------
   // y[n+1] = 2 cos(w) y[n] - y[n-1]
   // ----------------------------------------------------------------
   // RL10: recursion with the cosine coefficient; sine only seeds y[-1]
   assign prod      = $signed(cosine_i) * $signed(sample_o);
   assign next_wide = (prod >>> 14) - $signed({{18{prev[15]}}, prev});
   // saturate: rounding may push a full-scale peak past 0x7FFF
   assign next_sample = (next_wide > 34'sh0000_7FFF) ? 16'h7FFF :
                        (next_wide < -34'sh0000_8000) ? 16'h8000 :
                        next_wide[15:0];

   // state update; load seeds y[0]=0 and y[-1]=-sin(w)
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sample_o <= 16'h0000;
         prev     <= 16'h0000;
      end else if (ce_i) begin
         if (load_i) begin
            sample_o <= 16'h0000;
            prev     <= 16'h0000 - sine_i;
         end else if (step_i) begin
            sample_o <= next_sample;
            prev     <= sample_o;
         end
      end
   end

endmodule
